// *** design/pid_pkg.sv ***
// package: register map, field positions, reset values and scaling
package pid_pkg;
    // word indexes; byte address is four times the index
    localparam logic [5:0] IX_CTRL = 6'h00;
    localparam logic [5:0] IX_STAT = 6'h01;
    localparam logic [5:0] IX_SCAN = 6'h02;
    localparam logic [5:0] IX_PVC = 6'h04;
    localparam logic [5:0] IX_ASV = 6'h05;
    localparam logic [5:0] IX_CSV = 6'h06;
    localparam logic [5:0] IX_MMV = 6'h07;
    localparam logic [5:0] IX_TMV = 6'h08;
    localparam logic [5:0] IX_MODE = 6'h09;
    localparam logic [5:0] IX_KP = 6'h10;
    localparam logic [5:0] IX_TI = 6'h11;
    localparam logic [5:0] IX_TD = 6'h12;
    localparam logic [5:0] IX_GP = 6'h13;
    localparam logic [5:0] IX_ISV = 6'h14;
    localparam logic [5:0] IX_FT = 6'h15;
    localparam logic [5:0] IX_DSV = 6'h16;
    localparam logic [5:0] IX_MANUAL_RATE_LIMIT = 6'h17;
    localparam logic [5:0] IX_STS = 6'h18;
    localparam logic [5:0] IX_MH = 6'h19;
    localparam logic [5:0] IX_ML = 6'h1A;
    localparam logic [5:0] IX_DMV = 6'h1B;
    localparam logic [5:0] IX_N = 6'h1C;
    localparam logic [5:0] IX_MV = 6'h20;
    localparam logic [5:0] IX_E1 = 6'h21;
    localparam logic [5:0] IX_D1 = 6'h22;
    localparam logic [5:0] IX_PV1 = 6'h23;
    localparam logic [5:0] IX_SV1 = 6'h24;
    localparam logic [5:0] IX_IR = 6'h25;
    localparam logic [5:0] IX_DR = 6'h26;
    localparam logic [5:0] IX_MVI = 6'h27;
    localparam logic [5:0] IX_CNT = 6'h28;
    localparam logic [5:0] IX_DT = 6'h29;
    // field positions and codes
    localparam int EXEC_BIT = 0;
    localparam int TRK_BIT = 2;
    localparam int REV_BIT = 2;
    localparam logic [1:0] MODE_MAN = 2'h0;
    localparam logic [1:0] MODE_AUTO = 2'h1;
    localparam logic [1:0] MODE_CASC = 2'h2;
    // reset values
    localparam logic [15:0] RST_SCAN_MS = 16'h000A;
    localparam logic [15:0] RST_N = 16'h0001;
    // scaling: filter per mille, gain per cent, ms per 0.001 min
    localparam logic signed [47:0] FT_SCALE = 48'sh0003E8;
    localparam logic [31:0] FT_DEN = 32'h000003E8;
    localparam logic [31:0] KP_DEN = 32'h00000064;
    localparam logic signed [47:0] MIN_MS = 48'sh00003C;
    localparam logic signed [47:0] ETA_MS = 48'sh000006;
    localparam logic [5:0] DIV_STEPS = 6'h2F;
endpackage : pid_pkg

// *** design/pid_div.sv ***
// serial signed-by-unsigned divider used by the loop calculation
`timescale 1ns/1ps
module pid_div (
    // clock, reset, enable
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // request
    input wire logic go,
    input wire logic signed [47:0] num,
    input wire logic [31:0] den,
    // result
    output logic dv,
    output logic signed [47:0] quo,
    output logic signed [47:0] rem
);
    typedef struct packed {
        logic run;
        logic dv;
        logic neg;
        logic [5:0] cnt;
        logic [31:0] d;
        logic [32:0] r;
        logic [47:0] q;
        logic signed [47:0] quo;
        logic signed [47:0] rem;
    } pid_div_st_t;

    pid_div_st_t s;
    pid_div_st_t n;

    // one quotient bit per clock keeps the datapath small; truncation
    // is toward zero, remainder keeps the numerator sign for carrying
    always_comb begin
        logic [33:0] t;
        logic b;
        t = '0;
        b = 1'b0;
        n = s;
        n.dv = 1'b0;
        if (go && !s.run) begin
            n.neg = num[47];
            n.q = num[47] ? 48'(-num) : 48'(num);
            n.r = '0;
            n.d = den;
            n.cnt = pid_pkg::DIV_STEPS;
            n.run = (den != 32'h0);
            if (den == 32'h0) begin
                n.dv = 1'b1;
                n.quo = '0;
                n.rem = num;
            end
        end else if (s.run) begin
            t = {s.r, s.q[47]};
            b = (t >= {2'h0, s.d});
            if (b) begin
                t = t - {2'h0, s.d};
            end
            n.r = t[32:0];
            n.q = {s.q[46:0], b};
            if (s.cnt == 6'h0) begin
                n.run = 1'b0;
                n.dv = 1'b1;
                n.quo = s.neg ? -$signed(n.q) : $signed(n.q);
                n.rem = s.neg ? -$signed({15'h0, n.r})
                              : $signed({15'h0, n.r});
            end else begin
                n.cnt = s.cnt - 6'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s <= '0;
        end else if (ce) begin
            s <= n;
        end
    end

    assign dv = s.dv;
    assign quo = s.quo;
    assign rem = s.rem;
endmodule : pid_div

// *** design/pid_loop_controller.sv ***
// incremental pid loop with filter, dead-band, modes and wishbone map
`timescale 1ns/1ps
module pid_loop_controller (
    // clock, reset, enable
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // process side
    input wire logic scan_tick,
    output logic [15:0] manipulated_output,
    output logic calc_done,
    output logic calc_busy
);
    typedef enum logic [2:0] {
        S_IDLE, S_FILT, S_INT, S_DER, S_GAIN
    } pid_fsm_t;

    typedef struct packed {
        pid_fsm_t st;
        logic ack;
        logic [31:0] rdat;
        logic exec;
        logic done;
        logic [15:0] scan_ms;
        logic signed [15:0] process_input, auto_setpoint, cascade_setpoint, manual_output, tracking_input;
        logic [2:0] mode;
        logic signed [15:0] kp, ti, td, gp, initial_setpoint, ft, setpoint_rate_limit, manual_rate_limit;
        logic [2:0] sts;
        logic signed [15:0] mh, ml, output_rate_limit, n;
        logic signed [15:0] mv, e1, d1, pv1, sv1, cnt;
        logic signed [15:0] pv, e, di, mvs;
        logic signed [31:0] ir, dr, dt;
        logic lim_hi, lim_lo;
        logic go;
        logic signed [47:0] num;
        logic [31:0] den;
    } pid_state_t;

    pid_state_t s;
    pid_state_t n;
    logic div_dv;
    logic signed [47:0] div_quo;
    logic signed [47:0] div_rem;

    pid_div u_div (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .go(s.go),
        .num(s.num),
        .den(s.den),
        .dv(div_dv),
        .quo(div_quo),
        .rem(div_rem)
    );

    function automatic logic signed [15:0] sat16(
        input logic signed [47:0] x
    );
        if (x > 48'sh007FFF) begin
            return 16'sh7FFF;
        end
        if (x < -48'sh008000) begin
            return -16'sh8000;
        end
        return x[15:0];
    endfunction : sat16

    function automatic logic signed [47:0] clip(
        input logic signed [47:0] x,
        input logic signed [47:0] lo,
        input logic signed [47:0] hi
    );
        if (x > hi) begin
            return hi;
        end
        if (x < lo) begin
            return lo;
        end
        return x;
    endfunction : clip

    function automatic logic [15:0] wr16(
        input logic [15:0] old,
        input logic [31:0] d,
        input logic [3:0] sel
    );
        return {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction : wr16

    // code 3 is treated as manual, the safe place to land
    function automatic logic is_man(input logic [2:0] m);
        return m[1:0] != pid_pkg::MODE_AUTO
            && m[1:0] != pid_pkg::MODE_CASC;
    endfunction : is_man

    function automatic logic [31:0] rd_word(
        input pid_state_t x,
        input logic [5:0] i
    );
        logic [31:0] r;
        r = '0;
        case (i)
            pid_pkg::IX_CTRL: r = {31'h0, x.exec};
            pid_pkg::IX_STAT: r = {30'h0, x.exec, x.st != S_IDLE};
            pid_pkg::IX_SCAN: r = {16'h0, x.scan_ms};
            pid_pkg::IX_PVC: r = {16'h0, x.process_input};
            pid_pkg::IX_ASV: r = {16'h0, x.auto_setpoint};
            pid_pkg::IX_CSV: r = {16'h0, x.cascade_setpoint};
            pid_pkg::IX_MMV: r = {16'h0, x.manual_output};
            pid_pkg::IX_TMV: r = {16'h0, x.tracking_input};
            pid_pkg::IX_MODE: r = {29'h0, x.mode};
            pid_pkg::IX_KP: r = {16'h0, x.kp};
            pid_pkg::IX_TI: r = {16'h0, x.ti};
            pid_pkg::IX_TD: r = {16'h0, x.td};
            pid_pkg::IX_GP: r = {16'h0, x.gp};
            pid_pkg::IX_ISV: r = {16'h0, x.initial_setpoint};
            pid_pkg::IX_FT: r = {16'h0, x.ft};
            pid_pkg::IX_DSV: r = {16'h0, x.setpoint_rate_limit};
            pid_pkg::IX_MANUAL_RATE_LIMIT: r = {16'h0, x.manual_rate_limit};
            pid_pkg::IX_STS: r = {29'h0, x.sts};
            pid_pkg::IX_MH: r = {16'h0, x.mh};
            pid_pkg::IX_ML: r = {16'h0, x.ml};
            pid_pkg::IX_DMV: r = {16'h0, x.output_rate_limit};
            pid_pkg::IX_N: r = {16'h0, x.n};
            pid_pkg::IX_MV: r = {16'h0, x.mv};
            pid_pkg::IX_E1: r = {16'h0, x.e1};
            pid_pkg::IX_D1: r = {16'h0, x.d1};
            pid_pkg::IX_PV1: r = {16'h0, x.pv1};
            pid_pkg::IX_SV1: r = {16'h0, x.sv1};
            pid_pkg::IX_IR: r = x.ir;
            pid_pkg::IX_DR: r = x.dr;
            pid_pkg::IX_MVI: r = {16'h0, x.mv};
            pid_pkg::IX_CNT: r = {16'h0, x.cnt};
            pid_pkg::IX_DT: r = x.dt;
            default: r = '0;
        endcase
        return r;
    endfunction : rd_word

    // closes a pass: the present error and pv are the base of the next one
    function automatic pid_state_t fin(input pid_state_t x);
        pid_state_t y;
        y = x;
        y.e1 = x.e;
        y.pv1 = x.pv;
        y.done = 1'b1;
        y.st = S_IDLE;
        return y;
    endfunction : fin

    // derivative on pv, eta of 0.1 folded into td*6 ms
    function automatic pid_state_t der_start(input pid_state_t x);
        pid_state_t y;
        logic signed [47:0] a;
        logic signed [47:0] b;
        y = x;
        a = 48'(x.td);
        b = 48'(x.dt);
        y.num = a * pid_pkg::MIN_MS * (48'(x.pv1) - 48'(x.pv))
              - b * 48'(x.d1) + 48'(x.dr);
        y.den = 32'(b + a * pid_pkg::ETA_MS);
        y.go = 1'b1;
        y.st = S_DER;
        return y;
    endfunction : der_start

    always_comb begin
        logic signed [47:0] t;
        logic signed [47:0] u;
        logic signed [15:0] sv;
        logic signed [15:0] e;
        logic signed [15:0] q;
        logic [5:0] ix;
        logic rev;
        logic up;
        t = '0;
        u = '0;
        sv = '0;
        e = '0;
        q = '0;
        ix = wb_adr_i[7:2];
        rev = s.sts[pid_pkg::REV_BIT];
        up = 1'b0;
        n = s;
        n.go = 1'b0;
        n.done = 1'b0;
        n.ack = wb_cyc_i & wb_stb_i & ~s.ack;
        if (wb_cyc_i & wb_stb_i & ~s.ack) begin
            n.rdat = rd_word(s, ix);
        end
        // write lands on the edge where the master sees ack
        if (wb_cyc_i & wb_stb_i & wb_we_i & s.ack) begin
            case (ix)
                pid_pkg::IX_CTRL: if (wb_sel_i[0]) begin
                    n.exec = wb_dat_i[pid_pkg::EXEC_BIT];
                end
                pid_pkg::IX_SCAN: n.scan_ms = wr16(s.scan_ms, wb_dat_i, wb_sel_i);
                pid_pkg::IX_PVC: n.process_input = wr16(s.process_input, wb_dat_i, wb_sel_i);
                pid_pkg::IX_ASV: n.auto_setpoint = wr16(s.auto_setpoint, wb_dat_i, wb_sel_i);
                pid_pkg::IX_CSV: n.cascade_setpoint = wr16(s.cascade_setpoint, wb_dat_i, wb_sel_i);
                pid_pkg::IX_MMV: n.manual_output = wr16(s.manual_output, wb_dat_i, wb_sel_i);
                pid_pkg::IX_TMV: n.tracking_input = wr16(s.tracking_input, wb_dat_i, wb_sel_i);
                pid_pkg::IX_MODE: if (wb_sel_i[0]) begin
                    n.mode = wb_dat_i[2:0];
                end
                pid_pkg::IX_KP: n.kp = wr16(s.kp, wb_dat_i, wb_sel_i);
                pid_pkg::IX_TI: n.ti = wr16(s.ti, wb_dat_i, wb_sel_i);
                pid_pkg::IX_TD: n.td = wr16(s.td, wb_dat_i, wb_sel_i);
                pid_pkg::IX_GP: n.gp = wr16(s.gp, wb_dat_i, wb_sel_i);
                pid_pkg::IX_ISV: n.initial_setpoint = wr16(s.initial_setpoint, wb_dat_i, wb_sel_i);
                pid_pkg::IX_FT: n.ft = wr16(s.ft, wb_dat_i, wb_sel_i);
                pid_pkg::IX_DSV: n.setpoint_rate_limit = wr16(s.setpoint_rate_limit, wb_dat_i, wb_sel_i);
                pid_pkg::IX_MANUAL_RATE_LIMIT: n.manual_rate_limit = wr16(s.manual_rate_limit, wb_dat_i, wb_sel_i);
                pid_pkg::IX_STS: if (wb_sel_i[0]) begin
                    n.sts = wb_dat_i[2:0];
                end
                pid_pkg::IX_MH: n.mh = wr16(s.mh, wb_dat_i, wb_sel_i);
                pid_pkg::IX_ML: n.ml = wr16(s.ml, wb_dat_i, wb_sel_i);
                pid_pkg::IX_DMV: n.output_rate_limit = wr16(s.output_rate_limit, wb_dat_i, wb_sel_i);
                pid_pkg::IX_N: n.n = wr16(s.n, wb_dat_i, wb_sel_i);
                default: n.rdat = s.rdat;
            endcase
        end
        if (!s.exec) begin
            // initialise; the output itself is left alone
            n.mode[1:0] = s.sts[1:0];
            n.auto_setpoint = s.initial_setpoint;
            n.manual_output = s.mv;
            n.e1 = '0;
            n.d1 = '0;
            n.ir = '0;
            n.dr = '0;
            n.cnt = '0;
            n.lim_hi = 1'b0;
            n.lim_lo = 1'b0;
            n.pv1 = s.process_input;
            n.sv1 = s.initial_setpoint;
            n.st = S_IDLE;
        end else begin
            case (s.st)
                S_IDLE: if (scan_tick) begin
                    // n of zero or below behaves as one scan
                    if (s.n <= 16'sh0001 || s.cnt >= s.n - 16'sh0001) begin
                        n.cnt = '0;
                        t = (s.n <= 16'sh0001) ? 48'sh1 : 48'(s.n);
                        n.dt = 32'(t * 48'($unsigned(s.scan_ms)));
                        t = 48'(s.ft);
                        u = 48'(s.process_input);
                        n.num = (pid_pkg::FT_SCALE - t) * u
                              + t * 48'(s.pv1);
                        n.den = pid_pkg::FT_DEN;
                        n.go = 1'b1;
                        n.mvs = s.mv;
                        n.st = S_FILT;
                    end else begin
                        n.cnt = s.cnt + 16'sh0001;
                    end
                end
                S_FILT: if (div_dv) begin
                    n.pv = sat16(div_quo);
                    if (s.mode[1:0] == pid_pkg::MODE_CASC) begin
                        sv = s.cascade_setpoint;
                        n.auto_setpoint = s.cascade_setpoint;
                    end else if (s.mode[1:0] == pid_pkg::MODE_AUTO) begin
                        sv = sat16(48'(s.sv1) + clip(48'(s.auto_setpoint) - 48'(s.sv1),
                            -48'(s.setpoint_rate_limit), 48'(s.setpoint_rate_limit)));
                    end else begin
                        sv = s.auto_setpoint;
                    end
                    n.sv1 = sv;
                    e = sat16(48'(sv) - 48'(n.pv));
                    if (s.gp != 16'sh0000 && e <= s.gp && e >= -s.gp) begin
                        e = '0;
                    end
                    n.e = e;
                    if (is_man(s.mode)) begin
                        n.mv = sat16(48'(s.mv) + clip(48'(s.manual_output) - 48'(s.mv),
                            -48'(s.manual_rate_limit), 48'(s.manual_rate_limit)));
                        n.lim_hi = 1'b0;
                        n.lim_lo = 1'b0;
                        n = fin(n);
                    end else if (s.mode[pid_pkg::TRK_BIT]) begin
                        n.mv = sat16(clip(48'(s.tracking_input), 48'(s.ml),
                            48'(s.mh)));
                        n.manual_output = n.mv;
                        n.lim_hi = 1'b0;
                        n.lim_lo = 1'b0;
                        n = fin(n);
                    end else if (s.ti == 16'sh0000) begin
                        n.di = '0;
                        n = der_start(n);
                    end else begin
                        t = 48'(e);
                        u = 48'(s.dt);
                        n.num = t * u + 48'(s.ir);
                        t = 48'(s.ti);
                        n.den = 32'(t * pid_pkg::MIN_MS);
                        n.go = 1'b1;
                        n.st = S_INT;
                    end
                end
                S_INT: if (div_dv) begin
                    q = sat16(div_quo);
                    up = rev ? (q > 16'sh0000) : (q < 16'sh0000);
                    if ((s.lim_hi && up) || (s.lim_lo && !up && q != 0)) begin
                        n.di = '0;
                    end else begin
                        n.di = q;
                        n.ir = 32'(div_rem);
                    end
                    n = der_start(n);
                end
                S_DER: if (div_dv) begin
                    q = sat16(div_quo);
                    n.d1 = sat16(48'(s.d1) + 48'(q));
                    n.dr = 32'(div_rem);
                    t = 48'(s.kp);
                    n.num = t * (48'(s.e) - 48'(s.e1) + 48'(s.di)
                          + 48'(q));
                    n.den = pid_pkg::KP_DEN;
                    n.go = 1'b1;
                    n.st = S_GAIN;
                end
                S_GAIN: if (div_dv) begin
                    t = rev ? 48'(s.mv) + div_quo
                            : 48'(s.mv) - div_quo;
                    u = 48'(s.mv) + clip(t - 48'(s.mv), -48'(s.output_rate_limit),
                        48'(s.output_rate_limit));
                    u = clip(u, 48'(s.ml), 48'(s.mh));
                    n.lim_hi = t > u;
                    n.lim_lo = t < u;
                    n.mv = sat16(u);
                    n.manual_output = n.mv;
                    n = fin(n);
                end
                default: n.st = S_IDLE;
            endcase
        end
        // a bus write clearing exec on the closing edge suppresses done
        n.done = n.done & n.exec;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s <= '0;
            s.scan_ms <= pid_pkg::RST_SCAN_MS;
            s.n <= pid_pkg::RST_N;
        end else if (ce) begin
            s <= n;
        end
    end

    assign wb_dat_o = s.rdat;
    assign wb_ack_o = s.ack;
    assign manipulated_output = s.mv;
    assign calc_done = s.done;
    assign calc_busy = s.st != S_IDLE;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    a_done_needs_exec: assert property (s.done |-> s.exec)
        else $error("completion raised with execution low");
    a_init_mode_asv: assert property ((ce && !s.exec) |=>
        (s.mode[1:0] == $past(s.sts[1:0]) && s.auto_setpoint == $past(s.initial_setpoint)))
        else $error("init did not load mode and auto setpoint");
    a_init_mv_held: assert property ((ce && !s.exec) |=>
        (s.mv == $past(s.mv) && !s.done))
        else $error("output moved during init");
    a_auto_limits: assert property ((s.done && !is_man(s.mode)
        && s.ml <= s.mh) |-> (s.mv <= s.mh && s.mv >= s.ml))
        else $error("output outside its limits");
    a_manual_rate: assert property ((s.done && is_man(s.mode)) |->
        (int'(s.mv) - int'(s.mvs) <= int'(s.manual_rate_limit)
        && int'(s.mvs) - int'(s.mv) <= int'(s.manual_rate_limit)))
        else $error("manual step exceeds manual rate");
    a_auto_mmv_copy: assert property ((s.done && !is_man(s.mode))
        |-> s.manual_output == s.mv)
        else $error("manual output not tracking output");
    a_casc_asv_copy: assert property ((s.done && s.mode[1:0]
        == pid_pkg::MODE_CASC) |-> s.auto_setpoint == s.cascade_setpoint)
        else $error("auto setpoint not following cascade");
    a_ti_zero_int: assert property ((s.st == S_DER && s.ti == 0
        && $past(s.st) == S_FILT) |-> s.di == 0)
        else $error("integral nonzero with zero time");
    a_track_out: assert property ((s.done && !is_man(s.mode)
        && s.mode[pid_pkg::TRK_BIT] && s.ml <= s.mh) |->
        48'(s.mv) == clip(48'(s.tracking_input), 48'(s.ml), 48'(s.mh)))
        else $error("tracking output wrong");
    a_bus_ack_pulse: assert property ((ce && s.ack) |=> !s.ack)
        else $error("ack held longer than one cycle");

    c_manual_pass: cover property (s.done && is_man(s.mode));
    c_cascade_pass: cover property (s.done
        && s.mode[1:0] == pid_pkg::MODE_CASC);
    c_tracking_pass: cover property (s.done && s.mode[2]
        && !is_man(s.mode));
    c_limit_hold: cover property (s.done && (s.lim_hi || s.lim_lo));
endmodule : pid_loop_controller

// *** dv/pid_scan_model.sv ***
// constant-scan tick source standing in for the surrounding controller
`timescale 1ns/1ps
module pid_scan_model #(
    parameter int PERIOD = 400
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // scan
    output logic scan_tick
);
    int cnt;
    // period shortened from a real scan, but kept well above one pass
    always_ff @(posedge clk) begin
        cnt <= (!nrst || cnt == PERIOD - 1) ? 0 : cnt + 1;
        scan_tick <= nrst && cnt == PERIOD - 1;
    end
endmodule : pid_scan_model

// *** dv/test_pid_loop_controller.sv ***
// self-checking bench for the pid loop controller
`timescale 1ns/1ps
module test_pid_loop_controller;
    logic clk = 0;
    logic nrst = 0;
    logic cyc = 0;
    logic stb = 0;
    logic we = 0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h00000000;
    logic [31:0] rdat;
    logic [31:0] dout;
    logic ack, done, busy, tick;
    logic [15:0] mv;
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n_done = 0;
    int t0;
    always #25 clk = ~clk;
    pid_scan_model #(.PERIOD(400)) model (.clk(clk), .nrst(nrst),
        .scan_tick(tick));
    pid_loop_controller uut (.clk(clk), .nrst(nrst), .ce(1'b1),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack),
        .scan_tick(tick), .manipulated_output(mv), .calc_done(done),
        .calc_busy(busy));
    task complete_run;
        if (n_fail == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    always @(posedge clk) begin
        cycles++;
        if (done === 1'b1) n_done++;
        if (cycles == 40000) begin
            n_fail++;
            complete_run();
        end
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one classic cycle, held until ack is sampled high
    task bus(input logic w, input logic [5:0] ix, input logic [15:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {ix, 2'b00};
        dat <= {16'h0000, d};
        do @(posedge clk); while (ack !== 1'b1);
        rdat = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus
    task wr(input logic [5:0] ix, input logic [15:0] d);
        bus(1'b1, ix, d);
    endtask : wr
    task rd(input logic [5:0] ix, input logic [15:0] e);
        bus(1'b0, ix, 16'h0000);
        chk($sformatf("word %h", ix), {16'h0000, e}, rdat);
    endtask : rd
    // writes placed right after a pass land while the block is idle
    task wd(input logic [15:0] e);
        do @(posedge clk); while (done !== 1'b1);
        chk("mv", {16'h0000, e}, {16'h0000, mv});
        chk("busy", 32'h0, {31'h0, busy});
    endtask : wd
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        rd(pid_pkg::IX_SCAN, 16'h000A);
        rd(pid_pkg::IX_N, 16'h0001);
        rd(6'h3F, 16'h0000);
        wr(pid_pkg::IX_ML, 16'hF63C);
        wr(pid_pkg::IX_MH, 16'h1388);
        wr(pid_pkg::IX_MANUAL_RATE_LIMIT, 16'h2710);
        wr(pid_pkg::IX_DSV, 16'h2710);
        wr(pid_pkg::IX_DMV, 16'h2710);
        wr(pid_pkg::IX_ISV, 16'h1388);
        wr(pid_pkg::IX_PVC, 16'h0FA0);
        wr(pid_pkg::IX_KP, 16'h0064);
        repeat (1000) @(posedge clk);
        chk("done count", 32'h0, 32'(n_done));
        rd(pid_pkg::IX_MODE, 16'h0000);
        rd(pid_pkg::IX_ASV, 16'h1388);
        wr(pid_pkg::IX_CTRL, 16'h0001);
        wd(16'h0000);
        wr(pid_pkg::IX_MMV, 16'h1770);
        wd(16'h1770);
        wr(pid_pkg::IX_MANUAL_RATE_LIMIT, 16'h0064);
        wr(pid_pkg::IX_MMV, 16'h07D0);
        wd(16'h170C);
        wr(pid_pkg::IX_TMV, 16'h1B58);
        wr(pid_pkg::IX_MODE, 16'h0005);
        wd(16'h1388);
        rd(pid_pkg::IX_MMV, 16'h1388);
        wr(pid_pkg::IX_KP, 16'h0000);
        wr(pid_pkg::IX_CSV, 16'h0BB8);
        wr(pid_pkg::IX_MODE, 16'h0002);
        wd(16'h1388);
        rd(pid_pkg::IX_ASV, 16'h0BB8);
        wr(pid_pkg::IX_CTRL, 16'h0000);
        wr(pid_pkg::IX_MH, 16'h2EE0);
        wr(pid_pkg::IX_KP, 16'h0064);
        wr(pid_pkg::IX_STS, 16'h0005);
        rd(pid_pkg::IX_MODE, 16'h0001);
        chk("mv held", 32'h1388, {16'h0000, mv});
        wr(pid_pkg::IX_CTRL, 16'h0001);
        wd(16'h1770);
        wd(16'h1770);
        wr(pid_pkg::IX_CTRL, 16'h0000);
        wr(pid_pkg::IX_STS, 16'h0001);
        wr(pid_pkg::IX_CTRL, 16'h0001);
        wd(16'h1388);
        wr(pid_pkg::IX_CTRL, 16'h0000);
        wr(pid_pkg::IX_GP, 16'h03E8);
        wr(pid_pkg::IX_CTRL, 16'h0001);
        wd(16'h1388);
        wr(pid_pkg::IX_N, 16'h0003);
        wd(16'h1388);
        t0 = cycles;
        wd(16'h1388);
        chk("interval", 32'h3, 32'((cycles - t0 + 200) / 400));
        wr(pid_pkg::IX_N, 16'h0000);
        wd(16'h1388);
        t0 = cycles;
        wd(16'h1388);
        chk("interval", 32'h1, 32'((cycles - t0 + 200) / 400));
        // ti of 60 ms: 10000/60 gives 166 rem 40, then 10040/60 gives 167
        wr(pid_pkg::IX_CTRL, 16'h0000);
        wr(pid_pkg::IX_GP, 16'h0000);
        wr(pid_pkg::IX_TI, 16'h0001);
        wr(pid_pkg::IX_CTRL, 16'h0001);
        wd(16'h0EFA);
        wd(16'h0E53);
        complete_run();
    end
endmodule : test_pid_loop_controller
